// >>> verilog/bsh_handshake.sv
`timescale 1ns/1ps
// ****************************************
// Handler handshake sequencer
// ****************************************
// The two status pins decode straight from the state register, so
// each state shows its own pair, except present and the unused codes, which read not-busy.
// A hidden present state holds the fresh bin for one cycle while the
// pins still read not-busy; that cycle is the handler's setup time.
// Any trigger restarts the sequence, as the front-panel key does, so
// the handler needs no separate abort line.
// Triggers are taken in every state; the cost is that a late trigger
// throws away a finished sort that the handler never saw.
// The pass line keeps its last verdict until the next sort completes.
module bsh_handshake #(
   parameter int NUM_BINS = bsh_pkg::BIN_COUNT,
   parameter int DEB_CYC = bsh_pkg::DEBOUNCE_CYC
) (
   // Clock and synchronous reset
   input wire logic sys_clk,
   input wire logic rst,
   // Option strap and trigger sources
   input wire logic option_fitted,
   input wire logic key_trigger,
   input wire logic ext_trigger_n,
   // Remote control and run mode
   input wire logic remote_mode,
   input wire logic local_trigger_enable_cmd,
   input wire logic multi_frequency_mode,
   // Measurement engine side
   output logic meas_start,
   input wire logic meas_done,
   input wire logic sort_done,
   // Sort result, sampled with sort_done
   input wire logic [bsh_pkg::BIN_IDX_W-1:0] sort_bin,
   input wire logic sort_bin_valid,
   input wire logic limits_pass,
   input wire logic mf_fail,
   // Handler pins, all active low
   output logic busy_n,
   output logic sort_result_valid_n,
   output logic [NUM_BINS-1:0] bin_select_n,
   output logic pass_fail_n
);

   // ****************************************
   // Trigger qualification
   // ****************************************
   logic ext_clean_n;
   logic ext_level_r;
   logic ext_level_nxt;
   logic trig;

   // Contacts bounce, so only a level held for DEB_CYC cycles gets
   // through; the price is that much extra trigger latency
   bsh_debounce #(
      .STABLE_CYC(DEB_CYC)
   ) bsh_debounce_i (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw_n(ext_trigger_n),
      .clean_n(ext_clean_n)
   );

   // Held low counts as one press; a new trigger needs a release first
   always_comb begin
      ext_level_nxt = ~ext_clean_n;
   end

   // Reset matches the idle pin level, so no false edge follows reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_level_r <= 1'b0;
      end else begin
         ext_level_r <= ext_level_nxt;
      end
   end

   // Remote control masks the external input unless locally enabled
   // Key requests are masked only by the option strap: remote control gates only the pin
   assign trig = option_fitted & (key_trigger |
      (ext_level_nxt & ~ext_level_r &
      (~remote_mode | local_trigger_enable_cmd)));

   // ****************************************
   // Handshake sequencer
   // ****************************************
   // Sequencer state
   bsh_pkg::bsh_state_e state_r;
   bsh_pkg::bsh_state_e state_nxt;
   // Bins and verdict as last shown to the handler
   logic [NUM_BINS-1:0] bins_r;
   logic [NUM_BINS-1:0] bins_nxt;
   logic pass_n_r;
   logic pass_n_nxt;
   // Start pulse for the measurement engine
   logic start_r;
   logic start_nxt;

   // One-hot active-low decode of the chosen bin
   // An unchosen or out-of-range index leaves every line high
   function automatic logic [NUM_BINS-1:0] bin_decode(
      input logic [bsh_pkg::BIN_IDX_W-1:0] idx,
      input logic ok
   );
      logic [NUM_BINS-1:0] v;
      v = '1;
      for (int i = 0; i < NUM_BINS; i++) begin
         if (ok && (idx == bsh_pkg::BIN_IDX_W'(i))) begin
            v[i] = 1'b0;
         end
      end
      return v;
   endfunction : bin_decode

   // A trigger anywhere past power-up restarts the measurement
   always_comb begin
      state_nxt = state_r;
      bins_nxt = bins_r;
      pass_n_nxt = pass_n_r;
      start_nxt = 1'b0;
      // Without the option the pins sit in null and triggers are lost
      if (!option_fitted) begin
         state_nxt = bsh_pkg::BSH_NULL;
         bins_nxt = bsh_pkg::BINS_NONE;
      end else if (trig) begin
         // Abort any measurement or pending sort and begin afresh
         state_nxt = bsh_pkg::BSH_BUSY;
         start_nxt = 1'b1;
         // Bins just presented stay up, so falling valid never blanks them
         if ((state_r != bsh_pkg::BSH_READY) &&
            (state_r != bsh_pkg::BSH_PRESENT)) begin
            bins_nxt = bsh_pkg::BINS_NONE;
         end
      end else begin
         unique case (state_r)
            bsh_pkg::BSH_NULL: begin
               // Bins are already all high; valid low will claim nothing
               state_nxt = bsh_pkg::BSH_READY;
            end
            bsh_pkg::BSH_READY: begin
               // Old bins stay on the pins until the next measurement is done
               state_nxt = bsh_pkg::BSH_READY;
            end
            bsh_pkg::BSH_BUSY: begin
               // The part stays in the fixture until busy rises
               if (meas_done) begin
                  state_nxt = bsh_pkg::BSH_NOTBUSY;
                  bins_nxt = bsh_pkg::BINS_NONE;
               end
            end
            bsh_pkg::BSH_NOTBUSY: begin
               // Bins were blanked on entry; the part may be swapped now
               if (sort_done) begin
                  // Bins settle here one cycle before valid falls
                  bins_nxt = bin_decode(sort_bin, sort_bin_valid);
                  pass_n_nxt = ~(limits_pass &
                     ~(multi_frequency_mode & mf_fail));
                  state_nxt = bsh_pkg::BSH_PRESENT;
               end
            end
            bsh_pkg::BSH_PRESENT: begin
               // Valid falls a full cycle after the bins settled
               state_nxt = bsh_pkg::BSH_READY;
            end
            default: begin
               // Unused codes fall back to null; the bins keep their value
               state_nxt = bsh_pkg::BSH_NULL;
            end
         endcase
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   // Reset parks the pins in null with no bin and a fail verdict
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= bsh_pkg::BSH_NULL;
         bins_r <= bsh_pkg::BINS_NONE;
         pass_n_r <= bsh_pkg::PASS_N_RESET;
         start_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bins_r <= bins_nxt;
         pass_n_r <= pass_n_nxt;
         start_r <= start_nxt;
      end
   end

   // ****************************************
   // Handshake outputs
   // ****************************************
   // Busy low in null and busy; valid low in ready and busy
   assign busy_n = (state_r != bsh_pkg::BSH_NULL) &&
      (state_r != bsh_pkg::BSH_BUSY);
   // Valid falls only on entering ready or busy, after bins settled
   assign sort_result_valid_n = (state_r != bsh_pkg::BSH_READY) &&
      (state_r != bsh_pkg::BSH_BUSY);
   // Bins and verdict come from flip-flops, so the pins never glitch
   assign bin_select_n = bins_r;
   assign pass_fail_n = pass_n_r;
   // Registered start, one cycle after the trigger is taken
   assign meas_start = start_r;

endmodule : bsh_handshake

// >>> verilog/bsh_pkg.sv
package bsh_pkg;

   // ****************************************
   // Sizes and counts
   // ****************************************
   localparam int BIN_COUNT = 10;
   localparam int BIN_IDX_W = 4;
   // Debounce time for the external trigger, in microseconds
   localparam int DEBOUNCE_US = 10;
   localparam int CLK_MHZ = 40;
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
   localparam int DEB_CNT_W = 16;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [9:0] BINS_NONE = 10'h3FF;
   localparam logic PASS_N_RESET = 1'h1;

   // ****************************************
   // Handshake states, Gray coded along the usual path up to present; present to ready changes all three bits
   // ****************************************
   typedef enum logic [2:0] {
      BSH_NULL = 3'h0,
      BSH_READY = 3'h1,
      BSH_BUSY = 3'h3,
      BSH_NOTBUSY = 3'h2,
      BSH_PRESENT = 3'h6
   } bsh_state_e;

endpackage : bsh_pkg

// >>> verilog/bsh_debounce.sv
`timescale 1ns/1ps
// ****************************************
// Level debouncer for the external trigger
// ****************************************
module bsh_debounce #(
   parameter int STABLE_CYC = bsh_pkg::DEBOUNCE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic raw_n,
   output logic clean_n
);

   logic [bsh_pkg::DEB_CNT_W-1:0] cnt_r;
   logic [bsh_pkg::DEB_CNT_W-1:0] cnt_nxt;
   logic clean_r;
   logic clean_nxt;

   // Output follows the input only once it has held steady long enough
   always_comb begin
      cnt_nxt = cnt_r;
      clean_nxt = clean_r;
      if (raw_n == clean_r) begin
         cnt_nxt = '0;
      end else if (cnt_r >= bsh_pkg::DEB_CNT_W'(STABLE_CYC - 1)) begin
         cnt_nxt = '0;
         clean_nxt = raw_n;
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_r <= '0;
         clean_r <= 1'b1; // Idle high, like the pull-up
      end else begin
         cnt_r <= cnt_nxt;
         clean_r <= clean_nxt;
      end
   end

   assign clean_n = clean_r;

endmodule : bsh_debounce

// >>> dv/bsh_handshake_props.sv
`timescale 1ns/1ps
module bsh_handshake_props #(parameter int NUM_BINS = bsh_pkg::BIN_COUNT) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic option_fitted,
   input wire logic key_trigger,
   input wire logic remote_mode,
   input wire logic local_trigger_enable_cmd,
   input wire logic multi_frequency_mode,
   input wire logic meas_start,
   input wire logic meas_done,
   input wire logic sort_done,
   input wire logic [bsh_pkg::BIN_IDX_W-1:0] sort_bin,
   input wire logic sort_bin_valid,
   input wire logic limits_pass,
   input wire logic mf_fail,
   input wire logic busy_n,
   input wire logic sort_result_valid_n,
   input wire logic [NUM_BINS-1:0] bin_select_n,
   input wire logic pass_fail_n
);
   // Handshake states as seen at the pins
   wire rdy = busy_n && !sort_result_valid_n;
   wire bsy = !busy_n && !sort_result_valid_n;
   wire nb = busy_n && sort_result_valid_n;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_one; $countones(~bin_select_n) <= 1;
   endproperty
   a_one: assert property (p_one) else $error("two bins low");
   property p_ack; key_trigger && option_fitted |=> bsy;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_hold; bsy && !meas_done |=> !busy_n;
   endproperty
   a_hold: assert property (p_hold) else $error("busy dropped");
   property p_nb; bsy && meas_done && option_fitted && !key_trigger
      |=> nb && &bin_select_n;
   endproperty
   a_nb: assert property (p_nb) else $error("not busy");
   property p_sort; nb && sort_done && sort_bin_valid && option_fitted
      && !key_trigger
      |=> nb && !bin_select_n[$past(sort_bin)] ##1 rdy;
   endproperty
   a_sort: assert property (p_sort) else $error("sort");
   // Bins must already be settled on the edge the handler acts on
   property p_fall; $fell(sort_result_valid_n) |-> $stable(bin_select_n);
   endproperty
   a_fall: assert property (p_fall) else $error("bins moved");
   property p_pass; nb && sort_done && option_fitted && !key_trigger
      |=> pass_fail_n == !($past(limits_pass) &&
      !($past(multi_frequency_mode) && $past(mf_fail)));
   endproperty
   a_pass: assert property (p_pass) else $error("pass line");
   property p_start; key_trigger && option_fitted |=> meas_start;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_none; nb && sort_done && !sort_bin_valid && option_fitted
      && !key_trigger |=> nb && &bin_select_n ##1 rdy;
   endproperty
   a_none: assert property (p_none) else $error("no bin");
   property p_rem; remote_mode && !local_trigger_enable_cmd && rdy
      && option_fitted && !key_trigger |=> rdy;
   endproperty
   a_rem: assert property (p_rem) else $error("remote trig");
endmodule : bsh_handshake_props
bind bsh_handshake bsh_handshake_props #(
   .NUM_BINS(NUM_BINS)
) bsh_handshake_props_i (
   .sys_clk(sys_clk),
   .rst(rst),
   .option_fitted(option_fitted),
   .key_trigger(key_trigger),
   .remote_mode(remote_mode),
   .local_trigger_enable_cmd(local_trigger_enable_cmd),
   .multi_frequency_mode(multi_frequency_mode),
   .meas_start(meas_start),
   .meas_done(meas_done),
   .sort_done(sort_done),
   .sort_bin(sort_bin),
   .sort_bin_valid(sort_bin_valid),
   .limits_pass(limits_pass),
   .mf_fail(mf_fail),
   .busy_n(busy_n),
   .sort_result_valid_n(sort_result_valid_n),
   .bin_select_n(bin_select_n),
   .pass_fail_n(pass_fail_n)
);

// >>> dv/bsh_handler_model.sv
`timescale 1ns/1ps
module bsh_handler_model (
   input wire logic sys_clk,
   input wire logic trig_req,
   input wire logic sort_result_valid_n,
   input wire logic [9:0] bin_select_n,
   output logic ext_trigger_n,
   output logic [9:0] routed_n = 10'h3FF
);
   logic vld_n_r = 1'h1;
   // Contact closure; the pull-up leaves the line high when open
   assign ext_trigger_n = !trig_req;
   // Routes on the falling edge only, so null-state levels never count
   always @(posedge sys_clk) begin
      vld_n_r <= sort_result_valid_n;
      if (vld_n_r && !sort_result_valid_n) routed_n <= bin_select_n;
   end
endmodule : bsh_handler_model

// >>> dv/tb_bin_sorter_handshake.sv
`timescale 1ns/1ps
module tb_bin_sorter_handshake;
   logic sys_clk = 1'h0, rst = 1'h1, option_fitted = 1'h1;
   logic key_trigger = 1'h0, remote_mode = 1'h0, trig_req = 1'h0;
   logic local_trigger_enable_cmd = 1'h0, multi_frequency_mode = 1'h0;
   logic meas_done = 1'h0, sort_done = 1'h0, sort_bin_valid = 1'h1;
   logic limits_pass = 1'h0, mf_fail = 1'h0, ext_trigger_n, meas_start;
   logic busy_n, sort_result_valid_n, pass_fail_n;
   logic [3:0] sort_bin = 4'h0;
   logic [9:0] bin_select_n, routed_n;
   int miscompares = 0, compares = 0;
   // Short debounce keeps the run brief
   bsh_handshake #(.DEB_CYC(4)) bsh_handshake_i (.sys_clk, .rst,
      .option_fitted, .key_trigger, .ext_trigger_n, .remote_mode,
      .local_trigger_enable_cmd, .multi_frequency_mode, .meas_start,
      .meas_done, .sort_done, .sort_bin, .sort_bin_valid, .limits_pass,
      .mf_fail, .busy_n, .sort_result_valid_n, .bin_select_n, .pass_fail_n);
   bsh_handler_model bsh_handler_model_i (.sys_clk, .trig_req,
      .sort_result_valid_n, .bin_select_n, .ext_trigger_n, .routed_n);
   initial forever #12.5 sys_clk = ~sys_clk;
   function automatic logic [11:0] st();
      return {busy_n, sort_result_valid_n, bin_select_n};
   endfunction : st
   task automatic chk(string n, logic [11:0] e, logic [11:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic cyc(int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
   endtask : pulse
   // Bounded wait; running out ends the run at once
   task automatic wt(ref logic s, input logic v);
      for (int i = 0; i < 40 && s !== v; i++) cyc(1);
      chk("wait", v, s);
      if (s !== v) tally_and_finish();
   endtask : wt
   task automatic run(logic [3:0] b, logic lp, logic mf);
      logic [9:0] oh;
      oh = ~(10'h1 << b);
      pulse(key_trigger);
      wt(meas_start, 1'h1);
      chk("busy", 12'h0, st() >> 10);
      cyc(3);
      chk("hold", 12'h0, st() >> 10);
      chk("start", 12'h0, meas_start);
      pulse(meas_done);
      chk("nb", 12'hFFF, st());
      sort_bin = b;
      limits_pass = lp;
      mf_fail = mf;
      pulse(sort_done);
      cyc(1);
      chk("rdy", {2'h2, oh}, st());
      chk("pass", !(lp && !(multi_frequency_mode && mf)), pass_fail_n);
      cyc(1);
      chk("route", oh, routed_n);
   endtask : run
   task automatic abort;
      pulse(key_trigger);
      cyc(1);
      pulse(key_trigger);
      chk("again", 12'h3FF, st());
      chk("restart", 12'h1, meas_start);
      pulse(meas_done);
      pulse(key_trigger);
      chk("resort", 12'h3FF, st());
      cyc(1);
      run(4'h5, 1'h1, 1'h0);
   endtask : abort
   task automatic ext;
      remote_mode = 1'h1;
      trig_req = 1'h1;
      cyc(20);
      chk("remote", 12'h2, st() >> 10);
      trig_req = 1'h0;
      local_trigger_enable_cmd = 1'h1;
      cyc(10);
      trig_req = 1'h1;
      cyc(2);
      chk("deb", 12'h2, st() >> 10);
      wt(busy_n, 1'h0);
      trig_req = 1'h0;
      remote_mode = 1'h0;
      run(4'h7, 1'h0, 1'h0);
   endtask : ext
   task automatic nobin;
      pulse(key_trigger);
      pulse(meas_done);
      sort_bin_valid = 1'h0;
      limits_pass = 1'h1;
      pulse(sort_done);
      cyc(1);
      chk("nobin", 12'hBFF, st());
      chk("nobin pass", 12'h0, pass_fail_n);
      cyc(1);
      chk("noroute", 12'h3FF, routed_n);
      sort_bin_valid = 1'h1;
   endtask : nobin
   task automatic opt;
      rst = 1'h1;
      cyc(2);
      chk("rst", 12'h7FF, st());
      chk("rst pass", 12'h1, pass_fail_n);
      rst = 1'h0;
      cyc(2);
      chk("rst ready", 12'hBFF, st());
      option_fitted = 1'h0;
      cyc(2);
      pulse(key_trigger);
      chk("off", 12'h1, st() >> 10);
      option_fitted = 1'h1;
      cyc(2);
      chk("on", 12'h2, st() >> 10);
   endtask : opt
   initial begin
      cyc(20);
      chk("null", 12'h7FF, st());
      rst = 1'h0;
      cyc(2);
      chk("ready", 12'hBFF, st());
      for (int i = 0; i < 10; i++) run(i[3:0], i[0], i[1]);
      multi_frequency_mode = 1'h1;
      run(4'h2, 1'h1, 1'h1);
      run(4'h3, 1'h1, 1'h0);
      multi_frequency_mode = 1'h0;
      abort();
      ext();
      nobin();
      opt();
      tally_and_finish();
   end
endmodule : tb_bin_sorter_handshake
